/* File: core_bus.sv */
// Processor core model issuing register port cycles
`include "flash_self_program_defines.svh"
module core_bus (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle lines flip so a stale value never looks valid
  task automatic drop();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    drop();
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    drop();
    #1 d = reg_rdata;
  endtask
  task automatic unlock();
    wr(`OFS_UNLOCK, `KEY_FIRST);
    wr(`OFS_UNLOCK, `KEY_SECOND);
  endtask
endmodule

/* File: flash_self_program_control.sv */
// Flash self-program controller with register port and internal array
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "flash_self_program_defines.svh"
// Notes on behaviour
// - Data pair forms one word carrying a 14-bit program word.
// - Address pair forms one word holding a 15-bit word address.
// - Address pair reaches only the 1024 array words; higher addresses read zero and block writes.
// - Setting read trigger starts a read; write trigger starts program, erase or latch load.
// - Writing zero to triggers does nothing; operations cannot be aborted.
// - Hardware clears each trigger when its operation finishes.
// - Write or erase happens only while write enable is set.
// - Write enable reads cleared after power-up.
// - Reset during a write sets the error flag, readable afterwards.
// - Unlock key register is write-only and reads zero.
// - Writes to latches or array need the unlock pattern first.
// - Code protect never blocks self erase or self write.
// - Write-protect field blocks self write in a selected region.
// - Only power-up or an external bulk erase releases code protection.
// - Self erase works on whole rows only.
// - Hidden 14-bit write latches load through data pair writes.
// - Unprogrammed words can be programmed without row erase.
// - Internal timer sets program and erase duration.
// - A read takes two stall cycles; data ready right after.
// - Erase halts the core about 2 ms, then it resumes.
module flash_self_program_control
  import flash_self_program_pkg::*;
#(
  parameter int ADDR_W    = 15,
  parameter int DATA_W    = 14,
  parameter int ROW_WORDS = 16,
  parameter int MEM_WORDS = 1024,
  parameter int OP_CYCLES = `OP_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Configuration and status
  input  wire logic [1:0]        write_protect_region,
  input  wire logic              code_protect_n,
  input  wire logic              bulk_erase,
  input  wire logic              por,
  output logic                   core_stall,
  output logic                   ext_access_ok
);
  localparam int RW = $clog2(ROW_WORDS);
  localparam int MW = $clog2(MEM_WORDS);
  localparam int CW = $clog2(OP_CYCLES + 1);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Config and programmer pins arrive from outside the clock domain
  logic [4:0] pin_meta_ff;
  logic [4:0] pin_sync_ff;
  always_ff @(posedge clk) begin
    pin_meta_ff <= {por, bulk_erase, code_protect_n, write_protect_region};
    pin_sync_ff <= pin_meta_ff;
  end
  wire       por_s  = pin_sync_ff[4];
  wire       bulk_s = pin_sync_ff[3];
  wire       cp_n_s = pin_sync_ff[2];
  wire [1:0] wp_s   = pin_sync_ff[1:0];
  // ****************************************
  // State
  // ****************************************
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_ff;
  logic              rd_ff;
  logic              wr_ff;
  logic              write_enable_bit_ff;
  logic              write_error_flag_ff;
  logic              free_ff;
  logic              lwlo_ff;
  logic              cp_lock_ff;
  key_state_t        key_ff;
  seq_state_t        state_ff;
  logic [CW-1:0]     cnt_ff;
  logic [7:0]        rdata_ff;
  logic [DATA_W-1:0] latch_ff [ROW_WORDS];
  logic [ROW_WORDS-1:0] latch_v_ff;
  logic [DATA_W-1:0] mem [MEM_WORDS];
  // ****************************************
  // Decode
  // ****************************************
  wire wr_alow  = reg_wr && reg_addr == `OFS_ADDR_LOW;
  wire wr_ahigh = reg_wr && reg_addr == `OFS_ADDR_HIGH;
  wire wr_dlow  = reg_wr && reg_addr == `OFS_DATA_LOW;
  wire wr_dhigh = reg_wr && reg_addr == `OFS_DATA_HIGH;
  wire wr_ctrl  = reg_wr && reg_addr == `OFS_CONTROL;
  wire wr_key   = reg_wr && reg_addr == `OFS_UNLOCK;
  wire idle     = state_ff == ST_IDLE;
  // trigger set from software, only ones count
  wire set_rd   = wr_ctrl && reg_wdata[`BIT_RD] && idle;
  wire set_wr   = wr_ctrl && reg_wdata[`BIT_WR] && idle && !set_rd;
  wire [MW-1:0] word_idx = addr_ff[MW-1:0];
  wire [RW-1:0] row_slot = addr_ff[RW-1:0];
  wire [MW-1:0] row_base = {word_idx[MW-1:RW], {RW{1'b0}}};
  // protected region: 00 all, 01 lower half, 10 lower quarter, 11 none
  wire [MW-1:0] wp_limit = (wp_s == 2'b00) ?
                           MW'(MEM_WORDS - 1) :
                           (wp_s == 2'b01) ?
                           MW'(MEM_WORDS / 2 - 1) :
                           MW'(MEM_WORDS / 4 - 1);
  wire in_range  = addr_ff < ADDR_W'(MEM_WORDS);
  wire protected_row = wp_s != 2'b11 &&
                       word_idx <= wp_limit;
  // gate on enable and a full key
  wire wr_allowed = write_enable_bit_ff && key_ff == KEY_FULL;
  // code protect only affects the external port
  assign ext_access_ok = !cp_lock_ff;
  // core halts during read, erase and program
  assign core_stall = state_ff == ST_ERASE || state_ff == ST_PROG ||
                      state_ff == ST_READ;
  wire [7:0] ctrl_rd = {2'h0, lwlo_ff, free_ff, write_error_flag_ff, write_enable_bit_ff,
                        wr_ff, rd_ff};
  wire [7:0] nxt_rdata =
    (reg_addr == `OFS_ADDR_LOW)  ? addr_ff[7:0] :
    (reg_addr == `OFS_ADDR_HIGH) ? {1'b0, addr_ff[ADDR_W-1:8]} :
    (reg_addr == `OFS_DATA_LOW)  ? data_ff[7:0] :
    (reg_addr == `OFS_DATA_HIGH) ? {2'h0, data_ff[DATA_W-1:8]} :
    (reg_addr == `OFS_CONTROL)   ? ctrl_rd : 8'h00;
  assign reg_rdata = rdata_ff;
  always_ff @(posedge clk) begin
    if (rst) rdata_ff <= 8'h00;
    else if (reg_rd) rdata_ff <= nxt_rdata;
  end
  // ****************************************
  // Registers and key
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_ff <= '0;
      free_ff <= 1'b0;
      lwlo_ff <= 1'b0;
    end else begin
      // high byte feeds the top 7 address bits
      if (wr_alow) addr_ff[7:0] <= reg_wdata;
      if (wr_ahigh) addr_ff[ADDR_W-1:8] <= reg_wdata[6:0];
      if (wr_ctrl) begin
        free_ff <= reg_wdata[`BIT_FREE];
        lwlo_ff <= reg_wdata[`BIT_LWLO];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) write_enable_bit_ff <= 1'b0;
    else if (wr_ctrl) write_enable_bit_ff <= reg_wdata[`BIT_WRITE_ENABLE_BIT];
  end
  // error flag survives ordinary reset, cleared by power-up
  always_ff @(posedge clk) begin
    if (por_s) write_error_flag_ff <= 1'b0;
    else if (rst && (state_ff == ST_ERASE || state_ff == ST_PROG))
      write_error_flag_ff <= 1'b1;
    else if (wr_ctrl && !rst) write_error_flag_ff <= reg_wdata[`BIT_WRITE_ERROR_FLAG];
  end
  // lock cleared only by power-up or external bulk erase
  always_ff @(posedge clk) begin
    if (por_s || bulk_s) cp_lock_ff <= 1'b0;
    else if (!cp_n_s) cp_lock_ff <= 1'b1;
  end
  // key sequence, any other register write breaks it, except control writes once the key is full
  always_ff @(posedge clk) begin
    if (rst) key_ff <= KEY_NONE;
    else if (wr_key && reg_wdata == `KEY_FIRST) key_ff <= KEY_HALF;
    else if (wr_key && reg_wdata == `KEY_SECOND && key_ff == KEY_HALF)
      key_ff <= KEY_FULL;
    else if (reg_wr && !(wr_ctrl && key_ff == KEY_FULL)) key_ff <= KEY_NONE;
    else if (set_wr) key_ff <= KEY_NONE;
  end
  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (set_rd) nxt_state = ST_READ;
        else if (set_wr && wr_allowed && in_range && !protected_row) begin
          if (free_ff) nxt_state = ST_ERASE;
          else if (lwlo_ff) nxt_state = ST_LOAD;
          else nxt_state = ST_PROG;
        end
      end
      ST_READ:  if (cnt_ff == CW'(`READ_STALL - 1)) nxt_state = ST_IDLE;
      ST_LOAD:  nxt_state = ST_IDLE;
      ST_ERASE: if (cnt_ff == CW'(OP_CYCLES - 1)) nxt_state = ST_IDLE;
      ST_PROG:  if (cnt_ff == CW'(OP_CYCLES - 1)) nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) state_ff <= ST_IDLE;
    else state_ff <= nxt_state;
  end
  always_ff @(posedge clk) begin
    if (rst || nxt_state != state_ff || idle) cnt_ff <= '0;
    else cnt_ff <= cnt_ff + CW'(1);
  end
  // triggers are set only, cleared by hardware at the end
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      if (set_rd) rd_ff <= 1'b1;
      else if (state_ff == ST_READ && nxt_state == ST_IDLE) rd_ff <= 1'b0;
      if (set_wr && nxt_state != ST_IDLE) wr_ff <= 1'b1;
      else if (!idle && state_ff != ST_READ && nxt_state == ST_IDLE)
        wr_ff <= 1'b0;
    end
  end
  // data from array after the read stall
  always_ff @(posedge clk) begin
    if (rst) data_ff <= '0;
    else if (state_ff == ST_READ && nxt_state == ST_IDLE)
      data_ff <= in_range ? mem[word_idx] : '0;
    else begin
      if (wr_dlow) data_ff[7:0] <= reg_wdata;
      if (wr_dhigh) data_ff[DATA_W-1:8] <= reg_wdata[5:0];
    end
  end
  // ****************************************
  // Latches and array
  // ****************************************
  // latch loaded from data pair on unlocked write
  always_ff @(posedge clk) begin
    if (rst) latch_v_ff <= '0;
    else if (state_ff == ST_LOAD || (state_ff == ST_IDLE &&
             nxt_state == ST_PROG)) latch_v_ff[row_slot] <= 1'b1;
    else if (state_ff == ST_PROG && nxt_state == ST_IDLE) latch_v_ff <= '0;
  end
  always_ff @(posedge clk) begin
    if (state_ff == ST_LOAD || (idle && nxt_state == ST_PROG))
      latch_ff[row_slot] <= data_ff;
  end
  // erase whole row; program ANDs bits so blank words take data
  always_ff @(posedge clk) begin
    if (!rst && state_ff == ST_ERASE && nxt_state == ST_IDLE) begin
      for (int i = 0; i < ROW_WORDS; i++)
        mem[row_base | MW'(i)] <= `ERASED_WORD;
    end else if (!rst && state_ff == ST_PROG && nxt_state == ST_IDLE) begin
      for (int i = 0; i < ROW_WORDS; i++)
        if (latch_v_ff[i])
          mem[row_base | MW'(i)] <= mem[row_base | MW'(i)] & latch_ff[i];
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  trig_needs_key_a : assert property (@(posedge clk) disable iff (rst)
    (set_wr && !wr_allowed) |=> idle)
    else $error("write trigger ran without key or enable");
  rd_done_clear_a : assert property (@(posedge clk) disable iff (rst)
    set_rd |-> ##3 !rd_ff)
    else $error("read trigger not cleared");
  rd_stall_two_a : assert property (@(posedge clk) disable iff (rst)
    set_rd |=> core_stall [*2])
    else $error("read stall not two cycles");
  key_reads_zero_a : assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == `OFS_UNLOCK) |=> reg_rdata == 8'h00)
    else $error("unlock key read not zero");
  write_enable_bit_gate_a : assert property (@(posedge clk) disable iff (rst)
    (idle && nxt_state inside {ST_ERASE, ST_PROG, ST_LOAD}) |-> write_enable_bit_ff)
    else $error("operation without write enable");
  wp_block_a : assert property (@(posedge clk) disable iff (rst)
    (idle && protected_row) |=> state_ff inside {ST_IDLE, ST_READ})
    else $error("write into protected region");
  wr_no_abort_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_ERASE && nxt_state == ST_ERASE && wr_ctrl &&
     !reg_wdata[`BIT_WR]) |=> wr_ff)
    else $error("write trigger cleared by software");
  write_enable_bit_reset_a : assert property (@(posedge clk)
    rst |=> !write_enable_bit_ff)
    else $error("write enable set after reset");

  cnt_bound_a : assert property (@(posedge clk) disable iff (rst)
    cnt_ff <= CW'(OP_CYCLES - 1))
    else $error("operation timer overran");

  prog_end_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_PROG && cnt_ff == CW'(OP_CYCLES - 1)) |=> idle)
    else $error("program did not end on time");

  erase_end_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_ERASE && cnt_ff == CW'(OP_CYCLES - 1)) |=> idle)
    else $error("erase did not end on time");

  wr_busy_held_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff inside {ST_ERASE, ST_PROG, ST_LOAD}) |-> wr_ff)
    else $error("write trigger low while busy");

  idle_clear_a : assert property (@(posedge clk) disable iff (rst)
    idle |-> (!wr_ff && !rd_ff))
    else $error("trigger left set when idle");

  rd_busy_held_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_READ) |-> rd_ff)
    else $error("read trigger low during read");

  rd_start_a : assert property (@(posedge clk) disable iff (rst)
    set_rd |=> state_ff == ST_READ)
    else $error("read trigger did not start read");

  key_consumed_a : assert property (@(posedge clk) disable iff (rst)
    set_wr |=> key_ff == KEY_NONE)
    else $error("unlock key not consumed");

  key_order_a : assert property (@(posedge clk) disable iff (rst)
    (wr_key && key_ff != KEY_HALF) |=> key_ff != KEY_FULL)
    else $error("unlock reached without first byte");

  write_error_flag_set_a : assert property (@(posedge clk)
    (rst && !por_s && state_ff inside {ST_ERASE, ST_PROG}) |=> write_error_flag_ff)
    else $error("error flag not set by reset");

  erase_stall_a : assert property (@(posedge clk) disable iff (rst)
    (idle && nxt_state == ST_ERASE) |=> core_stall [*8])
    else $error("core not halted during erase");

  load_no_stall_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_LOAD) |-> !core_stall)
    else $error("core halted on latch load");

  lock_hold_a : assert property (@(posedge clk) disable iff (rst)
    (cp_lock_ff && !bulk_s && !por_s) |=> cp_lock_ff)
    else $error("code lock released without bulk erase");

  cp_no_block_a : assert property (@(posedge clk) disable iff (rst)
    (set_wr && wr_allowed && in_range && !protected_row) |=> !idle)
    else $error("permitted write did not start");

  range_block_a : assert property (@(posedge clk) disable iff (rst)
    (set_wr && !in_range) |=> idle)
    else $error("write outside array started");

  load_one_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_LOAD) |=> idle)
    else $error("latch load longer than one cycle");

  wp_all_a : assert property (@(posedge clk) disable iff (rst)
    (set_wr && wp_s == 2'b00) |=> idle)
    else $error("write ran with whole array protected");

  rd_stays_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_READ && nxt_state == ST_READ && wr_ctrl &&
     !reg_wdata[`BIT_RD]) |=> rd_ff)
    else $error("read trigger cleared by software");

  write_enable_bit_off_a : assert property (@(posedge clk) disable iff (rst)
    (set_wr && !write_enable_bit_ff) |=> idle)
    else $error("write ran without enable");

  latch_clear_a : assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_PROG && nxt_state == ST_IDLE) |=> latch_v_ff == '0)
    else $error("write latches not emptied");

  addr_high_a : assert property (@(posedge clk) disable iff (rst)
    wr_ahigh |=> addr_ff[ADDR_W-1:8] == $past(reg_wdata[6:0]))
    else $error("address high byte not stored");

  data_low_a : assert property (@(posedge clk) disable iff (rst)
    (wr_dlow && !(state_ff == ST_READ && nxt_state == ST_IDLE)) |=>
    data_ff[7:0] == $past(reg_wdata))
    else $error("data low byte not stored");
endmodule

/* File: flash_self_program_defines.svh */
// Offsets, field positions, keys, erased word value and timing for the flash self-program unit
`ifndef FLASH_SELF_PROGRAM_DEFINES_SVH
`define FLASH_SELF_PROGRAM_DEFINES_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_ADDR_LOW    4'h0
`define OFS_ADDR_HIGH   4'h1
`define OFS_DATA_LOW    4'h2
`define OFS_DATA_HIGH   4'h3
`define OFS_CONTROL     4'h4
`define OFS_UNLOCK      4'h5
// ****************************************
// Control register fields
// ****************************************
`define BIT_RD          0
`define BIT_WR          1
`define BIT_WRITE_ENABLE_BIT        2
`define BIT_WRITE_ERROR_FLAG       3
`define BIT_LWLO        5
`define BIT_FREE        4
// ****************************************
// Keys and timing
// ****************************************
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'hAA
`define ERASED_WORD     14'h3FFF
`define ERASE_TIME_US   2000
`define PROG_TIME_US    2000
`define CLK_MHZ         200
`define OP_CYCLES       (`ERASE_TIME_US * `CLK_MHZ)
`define READ_STALL      2
`endif

/* File: flash_self_program_pkg.sv */
// Types shared by the flash self-program unit
package flash_self_program_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_LOAD,
    ST_ERASE,
    ST_PROG
  } seq_state_t;
  typedef enum logic [1:0] {
    KEY_NONE,
    KEY_HALF,
    KEY_FULL
  } key_state_t;
endpackage

/* File: tb_top.sv */
// Self-checking bench for the flash self-program controller
`include "flash_self_program_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short op time keeps the run brief
  localparam int OPC = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic        bulk_erase = 1'b0;
  logic        code_protect_n = 1'b0;
  logic [1:0]  write_protect_region = 2'b11;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, b;
  logic        reg_wr, reg_rd, core_stall, ext_access_ok;
  logic [14:0] a;
  logic [13:0] d1, d2, w;
  int          err_total = 0;
  int          num_checks = 0;
  int          n;
  initial forever #2.5 clk = ~clk;
  core_bus u_core_bus (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  flash_self_program_control #(.OP_CYCLES(OPC))
    u_flash_self_program_control (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por(por),
    .write_protect_region(write_protect_region),
    .code_protect_n(code_protect_n), .bulk_erase(bulk_erase),
    .core_stall(core_stall), .ext_access_ok(ext_access_ok));
  // ****************************************
  // Checks and report
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [7:0] keep(input logic [7:0] v, input int r);
    return (r == 1) ? (v & 8'h7F) : (r == 3) ? (v & 8'h3F) : v;
  endfunction
  // ****************************************
  // Operations
  // ****************************************
  task automatic wait_stall(output int k);
    k = 0;
    #1;
    while (core_stall === 1'b1) begin
      k++;
      if (k > 1000) begin
        err_total++;
        wrap_up();
      end
      @(posedge clk);
      #1;
    end
  endtask
  task automatic setaddr(input logic [14:0] at);
    u_core_bus.wr(`OFS_ADDR_LOW, at[7:0]);
    u_core_bus.wr(`OFS_ADDR_HIGH, {1'b0, at[14:8]});
  endtask
  task automatic rdword(input logic [14:0] at, output logic [13:0] q);
    logic [7:0] lo, hi;
    setaddr(at);
    u_core_bus.wr(`OFS_CONTROL, 8'h01);
    wait_stall(n);
    chk(16'(n), 16'(`READ_STALL));
    u_core_bus.rd(`OFS_CONTROL, lo);
    chk(16'(lo[`BIT_RD]), 16'h0);
    u_core_bus.rd(`OFS_DATA_LOW, lo);
    u_core_bus.rd(`OFS_DATA_HIGH, hi);
    q = {hi[5:0], lo};
  endtask
  task automatic op(input logic [14:0] at, input logic [7:0] c);
    setaddr(at);
    // Mode and enable must stand before the trigger write
    u_core_bus.wr(`OFS_CONTROL, c & 8'hFD);
    u_core_bus.unlock();
    u_core_bus.wr(`OFS_CONTROL, c);
    wait_stall(n);
  endtask
  task automatic prog(input logic [14:0] at, input logic [13:0] d);
    u_core_bus.wr(`OFS_DATA_LOW, d[7:0]);
    u_core_bus.wr(`OFS_DATA_HIGH, {2'b00, d[13:8]});
    op(at, 8'h26);
    op(at, 8'h06);
    chk(16'(n >= OPC && n <= OPC + 2), 16'h1);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h353de879));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    u_core_bus.rd(`OFS_CONTROL, b);
    chk(16'(b[`BIT_WRITE_ENABLE_BIT]), 16'h0);
    u_core_bus.rd(`OFS_UNLOCK, b);
    chk(16'(b), 16'h0);
    for (int r = 0; r < 4; r++) begin
      d2[7:0] = 8'($urandom);
      u_core_bus.wr(4'(r), d2[7:0]);
      u_core_bus.rd(4'(r), b);
      chk(16'(b), 16'(keep(d2[7:0], r)));
    end
    a = 15'($urandom % 1024);
    op(a, 8'h16);
    chk(16'(n >= OPC && n <= OPC + 2), 16'h1);
    rdword(a & 15'h7FF0, w);
    chk(16'(w), 16'h3FFF);
    rdword(a | 15'h000F, w);
    chk(16'(w), 16'h3FFF);
    d1 = 14'($urandom);
    d2 = 14'($urandom);
    prog(a, d1);
    rdword(a, w);
    chk(16'(w), 16'(d1));
    rdword(a ^ 15'h1, w);
    chk(16'(w), 16'h3FFF);
    prog(a ^ 15'h1, d2);
    rdword(a ^ 15'h1, w);
    chk(16'(w), 16'(d2));
    rdword(a, w);
    chk(16'(w), 16'(d1));
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) write_protect_region <= (m == 3) ? 2'b00 : 2'b11;
      setaddr(a);
      u_core_bus.wr(`OFS_CONTROL, (m == 0) ? 8'h10 : 8'h14);
      if (m != 1) u_core_bus.wr(`OFS_UNLOCK, `KEY_FIRST);
      if (m == 2) u_core_bus.wr(`OFS_ADDR_LOW, a[7:0]);
      if (m != 1) u_core_bus.wr(`OFS_UNLOCK, `KEY_SECOND);
      u_core_bus.wr(`OFS_CONTROL, (m == 0) ? 8'h12 : 8'h16);
      #1 chk(16'(core_stall), 16'h0);
      u_core_bus.rd(`OFS_CONTROL, b);
      chk(16'(b[`BIT_WR]), 16'h0);
      rdword(a, w);
      chk(16'(w), 16'(d1));
    end
    @(posedge clk) write_protect_region <= 2'b11;
    setaddr(a);
    u_core_bus.wr(`OFS_CONTROL, 8'h14);
    u_core_bus.unlock();
    u_core_bus.wr(`OFS_CONTROL, 8'h16);
    u_core_bus.wr(`OFS_CONTROL, 8'h00);
    u_core_bus.rd(`OFS_CONTROL, b);
    chk(16'(b[`BIT_WR]), 16'h1);
    chk(16'(core_stall), 16'h1);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    u_core_bus.rd(`OFS_CONTROL, b);
    chk(16'(b[`BIT_WRITE_ERROR_FLAG]), 16'h1);
    chk(16'(ext_access_ok), 16'h0);
    @(posedge clk) code_protect_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(16'(ext_access_ok), 16'h0);
    @(posedge clk) bulk_erase <= 1'b1;
    @(posedge clk) bulk_erase <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(16'(ext_access_ok), 16'h1);
    wrap_up();
  end
endmodule
